/* rtl/aef_pkg.sv */
// Shared constants, types and helpers for the access error frame logic.
// Assumes one core clock domain; included by all design files through import.
package aef_pkg;

  // ----------------------------------------------------------------
  // Transfer attribute encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] TT_NORMAL    = 2'h0;
  localparam logic [1:0] TT_LINE_MOVE = 2'h1;
  localparam logic [2:0] TM_PUSH      = 3'h0;
  localparam logic [2:0] TM_USER_DATA = 3'h1;
  localparam logic [2:0] TM_USER_CODE = 3'h2;
  localparam logic [2:0] TM_SUP_DATA  = 3'h5;
  localparam logic [2:0] TM_SUP_CODE  = 3'h6;
  localparam logic [1:0] SIZE_LONG    = 2'h0;
  localparam logic [1:0] SIZE_LINE    = 2'h3;

  // ----------------------------------------------------------------
  // Status word and write-back status field positions
  // ----------------------------------------------------------------
  localparam int SSW_CP  = 15;
  localparam int SSW_CM  = 12;
  localparam int SSW_MA  = 11;
  localparam int SSW_ATC = 10;
  localparam int SSW_LK  = 9;
  localparam int READ_WRITE_FLAG  = 8;
  localparam int SSW_SZ  = 5;
  localparam int SSW_TT  = 3;
  localparam int SSW_TM  = 0;
  localparam int WBS_V   = 7;
  localparam int WBS_SZ  = 5;
  localparam int WBS_TT  = 3;
  localparam int WBS_TM  = 0;

  // ----------------------------------------------------------------
  // Frame formats and return read window
  // ----------------------------------------------------------------
  localparam logic [3:0]  FMT_FOUR_WORD = 4'h0;
  localparam logic [3:0]  FMT_ADDR_ERR  = 4'h2;
  localparam logic [3:0]  FMT_ACCESS    = 4'h7;
  localparam logic [15:0] LEGAL_FORMATS = 16'h009f;
  localparam logic [3:0]  RTE_OFF_FMT   = 4'h6;
  localparam logic [3:0]  RTE_OFF_SSW   = 4'hc;
  localparam logic [3:0]  RTE_OFF_LAST  = 4'hd;
  localparam logic [3:0]  RTE_STEP      = 4'h2;
  localparam logic [1:0]  RESH_TRACE    = 2'h0;
  localparam logic [1:0]  RESH_UNIMP    = 2'h1;
  localparam logic [1:0]  RESH_POST     = 2'h2;

  typedef enum logic [2:0] {K_FETCH, K_ADDR, K_READ, K_WRITE, K_PUSH, K_LINE} aef_kind_e;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Keeps the highest continuation request only
  function automatic logic [3:0] pick_one(input logic [3:0] req);
    pick_one = '0;
    if (req[3]) pick_one = 4'h8;
    else if (req[2]) pick_one = 4'h4;
    else if (req[1]) pick_one = 4'h2;
    else if (req[0]) pick_one = 4'h1;
  endfunction

  // Program space references become data references
  function automatic logic [2:0] conv_tm(input logic [2:0] tm);
    conv_tm = tm;
    if (tm == TM_USER_CODE) conv_tm = TM_USER_DATA;
    if (tm == TM_SUP_CODE) conv_tm = TM_SUP_DATA;
  endfunction

  function automatic logic [7:0] mk_wbs(input logic v, input logic [1:0] sz,
                                        input logic [1:0] tt, input logic [2:0] tm);
    mk_wbs = {v, sz, tt, tm};
  endfunction

endpackage

/* rtl/aef_access_class.sv */
// Access classifier for the data memory stage protection check.
// Assumes attributes come from logic on the core clock; purely combinational.
module aef_access_class
  import aef_pkg::*;
(
  // Access attributes
  input  logic       acc_prefetch,
  input  logic       acc_write,
  input  logic       acc_locked,
  input  logic [2:0] acc_tm,
  // Classification
  output logic       cls_write,
  output logic [2:0] cls_tm
);

  // ----------------------------------------------------------------
  // Classification
  // ----------------------------------------------------------------
  assign cls_write = acc_write || (acc_locked && !acc_prefetch);
  assign cls_tm    = acc_prefetch ? acc_tm : conv_tm(acc_tm);

endmodule

/* rtl/aef_rte_check.sv */
// Return-from-exception frame validation sequencer.
// Assumes a stack read port on the core clock that answers with ack or fault.
module aef_rte_check
  import aef_pkg::*;
(
  // Clock and reset
  input  logic        core_clk,
  input  logic        nrst,
  // Stack read port
  input  logic        rte_start,
  input  logic [15:0] rd_data,
  input  logic        rd_ack,
  input  logic        rd_fault,
  output logic        rd_req,
  output logic [3:0]  rd_offset,
  // Outcome
  output logic        format_exc,
  output logic        push_below,
  output logic [3:0]  new_format,
  output logic        resume,
  output logic        restart_movem,
  output logic        reshape,
  output logic [1:0]  reshape_kind
);

  typedef enum logic [1:0] {R_IDLE, R_READ, R_WAIT, R_DONE} aef_rte_state_e;

  aef_rte_state_e state;
  logic [3:0]     fmt;
  logic [3:0]     cont;
  logic           legal;

  assign legal = LEGAL_FORMATS[rd_data[15:12]];

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state <= R_IDLE; rd_req <= 1'b0; rd_offset <= '0; fmt <= '0; cont <= '0;
      format_exc <= 1'b0; push_below <= 1'b0; new_format <= '0; resume <= 1'b0;
      restart_movem <= 1'b0; reshape <= 1'b0; reshape_kind <= '0;
    end else begin
      rd_req <= 1'b0; format_exc <= 1'b0; push_below <= 1'b0;
      resume <= 1'b0; restart_movem <= 1'b0; reshape <= 1'b0;
      unique case (state)
        R_IDLE: if (rte_start) begin
          rd_offset <= '0;
          cont <= '0;
          state <= R_READ;
        end
        R_READ: begin
          rd_req <= 1'b1;
          state <= R_WAIT;
        end
        R_WAIT: if (rd_fault) begin
          push_below <= 1'b1;
          new_format <= FMT_ACCESS;
          state <= R_IDLE;
        end else if (rd_ack) begin
          if (rd_offset == RTE_OFF_FMT && !legal) begin
            format_exc <= 1'b1;
            push_below <= 1'b1;
            new_format <= FMT_FOUR_WORD;
            state <= R_IDLE;
          end else if (rd_offset == RTE_OFF_SSW ||
                       (rd_offset == RTE_OFF_FMT && rd_data[15:12] != FMT_ACCESS)) begin
            if (rd_offset == RTE_OFF_SSW) cont <= rd_data[SSW_CP:SSW_CM];
            state <= R_DONE;
          end else begin
            if (rd_offset == RTE_OFF_FMT) fmt <= rd_data[15:12];
            rd_offset <= rd_offset + RTE_STEP;
            state <= R_READ;
          end
        end
        R_DONE: begin
          state <= R_IDLE;
          if (fmt == FMT_ACCESS && |cont[3:1]) begin
            reshape <= 1'b1;
            reshape_kind <= cont[3] ? RESH_POST : (cont[2] ? RESH_UNIMP : RESH_TRACE);
          end else if (fmt == FMT_ACCESS && cont[0]) begin
            restart_movem <= 1'b1;
          end else begin
            resume <= 1'b1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  property p_read_window;
    rd_req |-> rd_offset < RTE_OFF_LAST && !rd_offset[0];
  endproperty
  a_read_window: assert property (p_read_window) else $error("Read outside window");

  property p_bad_format;
    (state == R_WAIT && rd_ack && !rd_fault && rd_offset == RTE_OFF_FMT && !legal)
      |=> format_exc && !resume ##1 !resume[*3];
  endproperty
  a_bad_format: assert property (p_bad_format) else $error("Illegal format resumed");

  property p_push_below;
    format_exc |-> push_below && new_format == FMT_FOUR_WORD && !rd_req;
  endproperty
  a_push_below: assert property (p_push_below) else $error("No frame pushed below");

  property p_reshape;
    reshape |-> !resume && !restart_movem && $past(state) == R_DONE;
  endproperty
  a_reshape: assert property (p_reshape) else $error("Reshape with resume");

endmodule

/* rtl/aef_frame_logic.sv */
// Access error frame builder with protection classifier and return checker.
// Assumes fault reports and pending write-backs come from core clock logic.
//
// Behaviour
// - At most one continuation flag is set in a built status word.
// - An illegal format code on return raises a format exception.
// - Faults during return validation push a new frame below; old frame untouched.
// - Fetch faults report modifier 2 in user mode and 6 in supervisor.
// - Fetch faults wait until outstanding accesses finish; no pending write-backs.
// - Fetch translation flag only for translation faults; address is logical prefetch.
// - Address errors stack a short frame with address bit 0 cleared.
// - Data faults save pending write-backs into the frame instead of performing.
// - Read half of locked transfers counts as a write for protection.
// - Non-prefetch program space references are reported as data references.
// - Read faults: read set, type 0, data modifier, slots one and two empty.
// - Push faults: write, type 0, modifier 0, physical address, full line.
// - Long word push faults encode the failing long word in address bits 3:2.
// - All four push data long words stay valid even for long size.
// - Write bus errors: address equals slot one address, slot one valid.
// - Line move write faults: type 1, logical address, slot one, full line.
// - Write page faults: slot one invalid, slot two valid.
// - Push is type 00 modifier 000; line move slots are type 01.
// - Slot three never holds a line move nor line size.
// - Return reads only frame offsets 0 through D.
// - Pending trace or float continuation reshapes the stack and starts it.
module aef_frame_logic
  import aef_pkg::*;
(
  // Clock and reset
  input  logic         core_clk,
  input  logic         nrst,
  // Data memory access classification
  input  logic         acc_valid,
  input  logic         acc_prefetch,
  input  logic         acc_write,
  input  logic         acc_locked,
  input  logic [2:0]   acc_tm,
  output logic         prot_write,
  output logic [2:0]   prot_tm,
  // Fault report
  input  logic         fault_valid,
  input  aef_kind_e    fault_kind,
  input  logic         fault_xlate,
  input  logic         fault_locked,
  input  logic         fault_misalign,
  input  logic [1:0]   fault_size,
  input  logic [2:0]   fault_tm,
  input  logic [31:0]  fault_addr,
  input  logic [31:0]  fault_wdata,
  input  logic [31:0]  fault_pc,
  input  logic [1:0]   fault_push_lw,
  input  logic [3:0]   fault_cont,
  input  logic         accesses_busy,
  output logic         fault_taken,
  // Pending write-backs
  input  logic [7:0]   wb2_status,
  input  logic [31:0]  wb2_addr,
  input  logic [31:0]  wb2_data,
  input  logic [7:0]   wb3_status,
  input  logic [31:0]  wb3_addr,
  input  logic [31:0]  wb3_data,
  input  logic [127:0] push_line,
  output logic         wb_hold,
  // Stacked frame image
  output logic         frame_valid,
  output logic [3:0]   frame_format,
  output logic [31:0]  frame_pc,
  output logic [15:0]  frame_ssw,
  output logic [31:0]  frame_fault_address,
  output logic [7:0]   frame_wbs1,
  output logic [7:0]   frame_wbs2,
  output logic [7:0]   frame_wbs3,
  output logic [31:0]  frame_wb1_addr,
  output logic [31:0]  frame_wb1_data,
  output logic [31:0]  frame_wb2_addr,
  output logic [31:0]  frame_wb2_data,
  output logic [31:0]  frame_wb3_addr,
  output logic [31:0]  frame_wb3_data,
  output logic [127:0] frame_push_data,
  // Return from exception
  input  logic         rte_start,
  input  logic [15:0]  rte_rd_data,
  input  logic         rte_rd_ack,
  input  logic         rte_rd_fault,
  output logic         rte_rd_req,
  output logic [3:0]   rte_rd_offset,
  output logic         rte_format_exc,
  output logic         rte_push_below,
  output logic [3:0]   rte_new_format,
  output logic         rte_resume,
  output logic         rte_restart_movem,
  output logic         rte_reshape,
  output logic [1:0]   rte_reshape_kind
);

  logic        cls_write;
  logic [2:0]  cls_tm;
  logic        take;
  logic        data_fault;
  logic [2:0]  data_tm;
  logic [3:0]  next_format;
  logic [15:0] next_ssw;
  logic [31:0] next_fa;
  logic [7:0]  next_wbs1;
  logic [7:0]  next_wbs2;
  logic [7:0]  next_wbs3;
  logic        wb2_from_fault;

  // ----------------------------------------------------------------
  // Protection classification
  // ----------------------------------------------------------------
  aef_access_class u_class (
    .acc_prefetch (acc_prefetch),
    .acc_write    (acc_write),
    .acc_locked   (acc_locked),
    .acc_tm       (acc_tm),
    .cls_write    (cls_write),
    .cls_tm       (cls_tm)
  );

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prot_write <= 1'b0;
      prot_tm    <= '0;
    end else begin
      prot_write <= acc_valid && cls_write;
      prot_tm    <= acc_valid ? cls_tm : '0;
    end
  end

  // ----------------------------------------------------------------
  // Fault acceptance
  // ----------------------------------------------------------------
  assign take       = fault_valid && !fault_taken &&
                      !(fault_kind == K_FETCH && accesses_busy);
  assign data_fault = fault_kind inside {K_READ, K_WRITE, K_PUSH, K_LINE};
  assign data_tm    = conv_tm(fault_tm);

  // ----------------------------------------------------------------
  // Frame field composition
  // ----------------------------------------------------------------
  always_comb begin
    next_format    = FMT_ACCESS;
    next_ssw       = '0;
    next_fa        = fault_addr;
    next_wbs1      = '0;
    next_wbs2      = wb2_status;
    next_wbs3      = wb3_status;
    wb2_from_fault = 1'b0;
    next_ssw[SSW_CP:SSW_CM]    = pick_one(fault_cont);
    next_ssw[SSW_LK]           = fault_locked;
    next_ssw[SSW_MA]           = fault_misalign;
    next_ssw[SSW_SZ +: 2]      = fault_size;
    next_ssw[SSW_TM +: 3]      = data_tm;
    unique case (fault_kind)
      K_FETCH: begin
        next_ssw[READ_WRITE_FLAG]      = 1'b1;
        next_ssw[SSW_ATC]     = fault_xlate;
        next_ssw[SSW_TM +: 3] = fault_tm[2] ? TM_SUP_CODE : TM_USER_CODE;
        next_wbs2             = '0;
        next_wbs3             = '0;
      end
      K_ADDR: begin
        next_format = FMT_ADDR_ERR;
        next_ssw    = '0;
        next_fa     = {fault_addr[31:1], 1'b0};
        next_wbs2   = '0;
        next_wbs3   = '0;
      end
      K_READ: begin
        next_ssw[READ_WRITE_FLAG]  = 1'b1;
        next_ssw[SSW_ATC] = fault_xlate;
        next_wbs2         = '0;
      end
      K_WRITE: begin
        next_ssw[SSW_ATC] = fault_xlate;
        if (fault_xlate) begin
          next_wbs2      = mk_wbs(1'b1, fault_size, TT_NORMAL, data_tm);
          wb2_from_fault = 1'b1;
        end else begin
          next_wbs1 = mk_wbs(1'b1, fault_size, TT_NORMAL, data_tm);
        end
      end
      K_PUSH: begin
        next_ssw[SSW_TM +: 3] = TM_PUSH;
        next_ssw[SSW_TT +: 2] = TT_NORMAL;
        next_ssw[SSW_CP:SSW_CM] = '0;
        next_fa = (fault_size == SIZE_LINE) ? {fault_addr[31:4], 4'h0} :
                  {fault_addr[31:4], fault_push_lw, 2'h0};
      end
      K_LINE: begin
        next_ssw[SSW_TT +: 2] = TT_LINE_MOVE;
        next_wbs1 = mk_wbs(1'b1, SIZE_LINE, TT_LINE_MOVE, data_tm);
      end
      default: ;
    endcase
    next_wbs3[WBS_TT +: 2] = TT_NORMAL;
    if (next_wbs3[WBS_SZ +: 2] == SIZE_LINE) next_wbs3[WBS_SZ +: 2] = SIZE_LONG;
  end

  // ----------------------------------------------------------------
  // Frame registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      fault_taken <= 1'b0;
      frame_valid <= 1'b0;
      wb_hold     <= 1'b0;
    end else begin
      fault_taken <= take;
      frame_valid <= take;
      wb_hold     <= take && data_fault;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      frame_format <= '0; frame_pc <= '0; frame_ssw <= '0; frame_fault_address <= '0;
      frame_wbs1 <= '0; frame_wbs2 <= '0; frame_wbs3 <= '0;
      frame_wb1_addr <= '0; frame_wb1_data <= '0; frame_wb2_addr <= '0;
      frame_wb2_data <= '0; frame_wb3_addr <= '0; frame_wb3_data <= '0;
      frame_push_data <= '0;
    end else if (take) begin
      frame_format        <= next_format;
      frame_pc            <= fault_pc;
      frame_ssw           <= next_ssw;
      frame_fault_address <= next_fa;
      frame_wbs1          <= next_wbs1;
      frame_wbs2          <= next_wbs2;
      frame_wbs3          <= next_wbs3;
      frame_wb1_addr      <= next_fa;
      frame_wb1_data      <= fault_wdata;
      frame_wb2_addr      <= wb2_from_fault ? fault_addr : wb2_addr;
      frame_wb2_data      <= wb2_from_fault ? fault_wdata : wb2_data;
      frame_wb3_addr      <= wb3_addr;
      frame_wb3_data      <= wb3_data;
      frame_push_data     <= (fault_kind inside {K_PUSH, K_LINE}) ? push_line : '0;
    end
  end

  // ----------------------------------------------------------------
  // Return validation
  // ----------------------------------------------------------------
  aef_rte_check u_rte (
    .core_clk      (core_clk),
    .nrst          (nrst),
    .rte_start     (rte_start),
    .rd_data       (rte_rd_data),
    .rd_ack        (rte_rd_ack),
    .rd_fault      (rte_rd_fault),
    .rd_req        (rte_rd_req),
    .rd_offset     (rte_rd_offset),
    .format_exc    (rte_format_exc),
    .push_below    (rte_push_below),
    .new_format    (rte_new_format),
    .resume        (rte_resume),
    .restart_movem (rte_restart_movem),
    .reshape       (rte_reshape),
    .reshape_kind  (rte_reshape_kind)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  property p_one_cont;
    frame_valid |-> $onehot0(frame_ssw[SSW_CP:SSW_CM]);
  endproperty
  a_one_cont: assert property (p_one_cont) else $error("Several continuation flags");

  property p_fetch_tm;
    (take && fault_kind == K_FETCH) |=> frame_valid &&
      frame_ssw[SSW_TM +: 3] == ($past(fault_tm[2]) ? 3'h6 : 3'h2);
  endproperty
  a_fetch_tm: assert property (p_fetch_tm) else $error("Fetch modifier wrong");

  property p_drain;
    (fault_valid && fault_kind == K_FETCH && accesses_busy) |=> !frame_valid;
  endproperty
  a_drain: assert property (p_drain) else $error("Fetch fault before drain");

  property p_fetch_fields;
    (take && fault_kind == K_FETCH) |=> frame_ssw[SSW_ATC] == $past(fault_xlate) &&
      frame_fault_address == $past(fault_addr) && frame_wbs3 == 8'h00;
  endproperty
  a_fetch_fields: assert property (p_fetch_fields) else $error("Fetch frame fields wrong");

  property p_addr_err;
    (take && fault_kind == K_ADDR) |=> frame_format == FMT_ADDR_ERR &&
      frame_fault_address == {$past(fault_addr[31:1]), 1'b0} && frame_pc == $past(fault_pc);
  endproperty
  a_addr_err: assert property (p_addr_err) else $error("Address error frame wrong");

  property p_hold;
    (take && fault_kind inside {K_READ, K_WRITE, K_PUSH, K_LINE}) |=> wb_hold ##1 !wb_hold;
  endproperty
  a_hold: assert property (p_hold) else $error("Write-backs not held");

  property p_locked_prot;
    (acc_valid && acc_locked && !acc_prefetch) |=> prot_write;
  endproperty
  a_locked_prot: assert property (p_locked_prot) else $error("Locked read not write");

  property p_data_tm;
    (acc_valid && !acc_prefetch) |=> prot_tm != 3'h2 && prot_tm != 3'h6;
  endproperty
  a_data_tm: assert property (p_data_tm) else $error("Program space not converted");

  property p_read_frame;
    (frame_valid && frame_ssw[READ_WRITE_FLAG] && frame_format == FMT_ACCESS) |->
      frame_wbs1 == 8'h00 && frame_wbs2 == 8'h00 && frame_ssw[SSW_TT +: 2] == 2'h0;
  endproperty
  a_read_frame: assert property (p_read_frame) else $error("Read frame slots wrong");

  property p_push_lw;
    (take && fault_kind == K_PUSH && fault_size != SIZE_LINE) |=>
      frame_fault_address[3:2] == $past(fault_push_lw) && frame_ssw[2:0] == 3'h0 &&
      frame_push_data == $past(push_line);
  endproperty
  a_push_lw: assert property (p_push_lw) else $error("Push frame wrong");

  property p_write_be;
    (take && fault_kind == K_WRITE && !fault_xlate) |=>
      frame_wbs1[WBS_V] && frame_fault_address == frame_wb1_addr;
  endproperty
  a_write_be: assert property (p_write_be) else $error("Write bus error frame wrong");

  property p_page_fault;
    (take && fault_kind == K_WRITE && fault_xlate) |=> !frame_wbs1[WBS_V] && frame_wbs2[WBS_V];
  endproperty
  a_page_fault: assert property (p_page_fault) else $error("Page fault slots wrong");

  property p_slot3;
    frame_valid |-> frame_wbs3[WBS_TT +: 2] != TT_LINE_MOVE && frame_wbs3[WBS_SZ +: 2] != SIZE_LINE;
  endproperty
  a_slot3: assert property (p_slot3) else $error("Slot three holds line");

endmodule

/* dv/aef_frame_logic_tb.sv */
// Self-checking bench for the access error frame logic.
// Assumes the top module alone, driven on the falling core clock edge.
module aef_frame_logic_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import aef_pkg::*;
  logic core_clk = 1'b0;
  logic nrst, acc_valid, acc_prefetch, acc_write, acc_locked, fault_valid, fault_xlate;
  logic fault_locked, fault_misalign, accesses_busy, rte_start, rte_rd_ack, rte_rd_fault;
  logic prot_write, fault_taken, wb_hold, frame_valid, rte_rd_req, rte_format_exc;
  logic rte_push_below, rte_resume, rte_restart_movem, rte_reshape;
  logic [1:0] fault_size, fault_push_lw, rte_reshape_kind;
  logic [2:0] acc_tm, fault_tm, prot_tm;
  logic [3:0] fault_cont, frame_format, rte_rd_offset, rte_new_format;
  logic [7:0] wb2_status, wb3_status, frame_wbs1, frame_wbs2, frame_wbs3;
  logic [15:0] rte_rd_data, frame_ssw;
  logic [31:0] fault_addr, fault_wdata, fault_pc, wb2_addr, wb2_data, wb3_addr, wb3_data;
  logic [31:0] frame_pc, frame_fault_address, frame_wb1_addr, frame_wb1_data;
  logic [31:0] frame_wb2_addr, frame_wb2_data, frame_wb3_addr, frame_wb3_data;
  logic [127:0] push_line, frame_push_data;
  aef_kind_e fault_kind;
  int fails = 0;
  int comparisons = 0;
  aef_frame_logic dut (.*);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [2:0] ctm(input logic [2:0] t);
    ctm = (t == 3'h2) ? 3'h1 : (t == 3'h6) ? 3'h5 : t;
  endfunction
  function automatic logic [4:0] ex(input logic [3:0] fm, ct, fo);
    if (fo != 4'hf) ex = 5'h08;
    else if (!LEGAL_FORMATS[fm]) ex = 5'h18;
    else if (fm != FMT_ACCESS || ct == 4'h0) ex = 5'h04;
    else if (ct[3:1] != 3'h0) ex = 5'h01;
    else ex = 5'h02;
  endfunction
  task automatic chk(input logic [191:0] g, e);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask
  task automatic end_sim;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Fault report
  // ----------------------------------------------------------------
  task automatic flt(input aef_kind_e k);
    int n;
    logic [15:0] s;
    @(negedge core_clk);
    {fault_xlate, fault_locked, fault_misalign, fault_size, fault_tm, fault_push_lw,
     fault_cont} = 14'($urandom);
    if (k == K_PUSH) fault_size[0] = fault_size[1];
    {fault_addr, fault_pc, fault_wdata, wb2_status, wb3_status} = {$urandom, $urandom,
     $urandom, 16'($urandom)};
    {wb2_addr, wb2_data, wb3_addr, wb3_data} = {$urandom, $urandom, $urandom, $urandom};
    push_line = {$urandom, $urandom, $urandom, $urandom};
    fault_kind = k;
    fault_valid = 1'b1;
    accesses_busy = (k == K_FETCH);
    if (k == K_FETCH) begin
      repeat (3) begin
        @(posedge core_clk);
        #1;
        chk(fault_taken, 1'b0);
      end
      @(negedge core_clk);
      accesses_busy = 1'b0;
    end
    n = 0;
    while (fault_taken !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n == 20) fails++;
    @(negedge core_clk);
    fault_valid = 1'b0;
    s = frame_ssw;
    chk($countones(s[15:12]) <= 1, 1'b1);
    chk(frame_wbs3[4:3] != TT_LINE_MOVE && frame_wbs3[6:5] != SIZE_LINE, 1'b1);
    if (k == K_FETCH || k == K_WRITE) chk(wb_hold, k == K_WRITE);
    if (k >= K_READ) chk({frame_valid, frame_wb3_addr, frame_wb3_data, frame_wb2_data},
      {1'b1, wb3_addr, wb3_data, (k == K_WRITE && fault_xlate) ? fault_wdata : wb2_data});
    case (k)
      K_FETCH: chk({s[8], s[10], s[2:0], frame_fault_address, frame_wbs2, frame_wbs3},
        {1'b1, fault_xlate, fault_tm[2] ? TM_SUP_CODE : TM_USER_CODE, fault_addr, 16'h0});
      K_ADDR: chk({frame_format, frame_fault_address, frame_pc},
        {FMT_ADDR_ERR, fault_addr[31:1], 1'b0, fault_pc});
      K_READ: chk({s[8], s[4:0], frame_fault_address, frame_wbs1, frame_wbs2},
        {1'b1, TT_NORMAL, ctm(fault_tm), fault_addr, 16'h0});
      K_WRITE: if (fault_xlate) chk({frame_wbs1[7], frame_wbs2[7]}, 2'b01);
        else chk({s[8], s[4:3], frame_wbs1[7], frame_fault_address, frame_wb1_addr},
        {3'b000, 1'b1, fault_addr, fault_addr});
      K_PUSH: chk({s[8], s[6:0], frame_fault_address, frame_push_data}, {1'b0, fault_size, 5'h00,
        fault_addr[31:4], fault_size[0] ? 4'h0 : {fault_push_lw, 2'b00}, push_line});
      default: chk({s[4:3], frame_wbs1[7:3], frame_fault_address, frame_push_data},
        {TT_LINE_MOVE, 1'b1, SIZE_LINE, TT_LINE_MOVE, fault_addr, push_line});
    endcase
  endtask
  // ----------------------------------------------------------------
  // Return validation
  // ----------------------------------------------------------------
  task automatic rte(input logic [3:0] fm, ct, fo);
    int n;
    logic [4:0] o;
    logic [3:0] ro;
    @(negedge core_clk);
    rte_start = 1'b1;
    @(negedge core_clk);
    rte_start = 1'b0;
    o = 5'h0;
    n = 0;
    while (o == 5'h0 && n < 60) begin
      @(posedge core_clk);
      #1;
      n++;
      o = {rte_format_exc, rte_push_below, rte_resume, rte_restart_movem, rte_reshape};
      if (rte_rd_req === 1'b1) begin
        ro = rte_rd_offset;
        chk(ro <= RTE_OFF_LAST && !ro[0], 1'b1);
        @(negedge core_clk);
        rte_rd_data = (ro == RTE_OFF_FMT) ? {fm, 12'h0} :
                      (ro == RTE_OFF_SSW) ? {ct, 12'h0} : 16'($urandom);
        rte_rd_fault = (ro == fo);
        rte_rd_ack = (ro != fo);
        @(posedge core_clk);
        #1;
        o = {rte_format_exc, rte_push_below, rte_resume, rte_restart_movem, rte_reshape};
        @(negedge core_clk);
        {rte_rd_ack, rte_rd_fault} = 2'b00;
      end
      if (o[3]) chk(rte_new_format, (fo != 4'hf) ? FMT_ACCESS : FMT_FOUR_WORD);
    end
    chk(o, ex(fm, ct, fo));
    if (o[0]) chk(rte_reshape_kind, ct[3] ? RESH_POST : ct[2] ? RESH_UNIMP : RESH_TRACE);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial forever #50 core_clk = ~core_clk;
  initial begin
    #1_000_000;
    fails++;
    end_sim();
  end
  initial begin
    {nrst, acc_valid, acc_prefetch, acc_write, acc_locked, acc_tm, fault_valid, fault_xlate,
     fault_locked, fault_misalign, fault_size, fault_tm, fault_push_lw, fault_cont,
     accesses_busy, rte_start, rte_rd_ack, rte_rd_fault, rte_rd_data} = '0;
    {fault_addr, fault_wdata, fault_pc, wb2_status, wb3_status, push_line} = '0;
    {wb2_addr, wb2_data, wb3_addr, wb3_data} = '0;
    fault_kind = K_FETCH;
    void'($urandom(32'h5be0_96c4));
    repeat (10) @(posedge core_clk);
    @(negedge core_clk);
    nrst = 1'b1;
    repeat (40) begin
      @(negedge core_clk);
      {acc_valid, acc_prefetch, acc_write, acc_locked, acc_tm} = 7'($urandom);
      @(posedge core_clk);
      #1;
      chk({prot_write, prot_tm}, {acc_valid & (acc_write | (acc_locked & !acc_prefetch)),
        acc_valid ? (acc_prefetch ? acc_tm : ctm(acc_tm)) : 3'h0});
    end
    repeat (4) for (int k = 0; k < 6; k++) flt(aef_kind_e'(k));
    for (int i = 0; i < 16; i++) rte(4'(i), 4'($urandom), 4'hf);
    for (int j = 0; j < 5; j++) rte(FMT_ACCESS, 4'((1 << j) >> 1), 4'hf);
    rte(FMT_ACCESS, 4'h0, 4'h0);
    rte(FMT_ACCESS, 4'h2, RTE_OFF_SSW);
    end_sim();
  end
endmodule
